// ===== rtl/ofs_consts.vh
// ofs_consts.vh - constants for the output function select block
// assumes inclusion by bare name from rtl and testbench files
`ifndef OFS_CONSTS_VH
`define OFS_CONSTS_VH

// selection code width and codes
`define OFS_SEL_W          4
`define OFS_SEL_LBD_ON     4'h0
`define OFS_SEL_LBD_OFF    4'h1
`define OFS_SEL_GEN_ON     4'h2
`define OFS_SEL_GEN_OFF    4'h3
`define OFS_SEL_EVT_ON     4'h4
`define OFS_SEL_EVT_OFF    4'h5
`define OFS_SEL_BAT2_ON    4'h6
`define OFS_SEL_BAT2_OFF   4'h7
`define OFS_SEL_ALRM_OFF   4'h8
`define OFS_SEL_ALRM_ON    4'h9
`define OFS_SEL_DIV_REG    4'hA
`define OFS_SEL_DIV_INV    4'hB

// reset values of the two selections
`define OFS_LOAD_SEL_RST   4'h1
`define OFS_AUX_SEL_RST    4'h2

// modulation setting codes
`define OFS_PWM_W          2
`define OFS_PWM_NONE       2'h0
`define OFS_PWM_SOLAR      2'h1
`define OFS_PWM_LOAD       2'h2
`define OFS_PWM_BOTH       2'h3

// register offsets on the plain register port
`define OFS_ADDR_W         4
`define OFS_REG_LOAD_SEL   4'h0
`define OFS_REG_AUX_SEL    4'h4
`define OFS_REG_PWM_SEL    4'h8
`define OFS_REG_STATUS     4'hC

// status field positions
`define OFS_ST_LOAD_OUT    0
`define OFS_ST_AUX_OUT     1
`define OFS_ST_LOAD_IND    2
`define OFS_ST_GEN_IND     3
`define OFS_ST_BAD_CFG     4

`endif

// ===== rtl/ofs_term_mux.v
// ofs_term_mux.v - one terminal's function and polarity decode
// assumes: function levels are already in the clk_sys domain
`timescale 1ns/100ps
`include "ofs_consts.vh"

module ofs_term_mux (
    input  wire [3:0] sel,
    input  wire       fn_lbd,
    input  wire       fn_gen,
    input  wire       fn_evt,
    input  wire       fn_bat2,
    input  wire       fn_alarm,
    input  wire       fn_div,
    output reg        drive_on
);

    // even codes on when active, except alarm and diversion pairs
    always @* begin
        case (sel)
            `OFS_SEL_LBD_ON:   drive_on = fn_lbd;
            `OFS_SEL_LBD_OFF:  drive_on = ~fn_lbd;
            `OFS_SEL_GEN_ON:   drive_on = fn_gen;
            `OFS_SEL_GEN_OFF:  drive_on = ~fn_gen;
            `OFS_SEL_EVT_ON:   drive_on = fn_evt;
            `OFS_SEL_EVT_OFF:  drive_on = ~fn_evt;
            `OFS_SEL_BAT2_ON:  drive_on = fn_bat2;
            `OFS_SEL_BAT2_OFF: drive_on = ~fn_bat2;
            `OFS_SEL_ALRM_OFF: drive_on = ~fn_alarm;
            `OFS_SEL_ALRM_ON:  drive_on = fn_alarm;
            `OFS_SEL_DIV_REG:  drive_on = ~fn_div;
            `OFS_SEL_DIV_INV:  drive_on = fn_div;
            default:           drive_on = 1'b0;
        endcase
    end

endmodule

// ===== rtl/ofs_output_select.v
// ofs_output_select.v - routes six controller functions to two outputs
// assumes: function and modulation inputs come from logic on clk_sys,
// the alarm comparison is made upstream, registers on a plain port
//
// Function
// - two switched outputs, each driven by one of six functions
// - load select picks function and polarity for the load terminal
// - aux select picks function and polarity for the general terminal
// - codes 0/1: on/off while low battery disconnect is active
// - codes 2/3: on/off while generator should run; aux default 2
// - codes 4/5: on/off while the event is on
// - codes 6/7: on/off while second battery should charge
// - codes 8/9: off/on while battery below alarm threshold
// - codes 10/11: off/on when diversion wants dump load off
// - general terminal never modulated, switches slowly only
// - series and diversion control may run together or alone
// - diversion switches a dump load, source stays connected
// - low battery disconnect lights load indicator whenever active
// - generator request lights generator indicator
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "ofs_consts.vh"

module ofs_output_select (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire       clk_en,
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       fn_lbd,
    input  wire       fn_gen,
    input  wire       fn_evt,
    input  wire       fn_bat2,
    input  wire       fn_alarm,
    input  wire       fn_div,
    input  wire       pwm_tick,
    input  wire       series_on,
    output reg        load_out,
    output reg        aux_out,
    output reg        solar_out,
    output reg        load_indicator,
    output reg        generator_indicator
);

    ////////////////////////////////////////////////////////////////////
    // configuration registers

    reg [3:0] load_output_select_r;
    reg [3:0] aux_output_select_r;
    reg [1:0] pwm_select_r;
    reg [7:0] rdata_nxt;

    // true when the load terminal is asked to carry modulation
    function pwm_on_load;
        input [1:0] mode;
        begin
            pwm_on_load = (mode == `OFS_PWM_LOAD) ||
                          (mode == `OFS_PWM_BOTH);
        end
    endfunction

    // writes of one cycle; only low nibble or two bits are kept
    always @(posedge clk_sys) begin
        if (rst) begin
            load_output_select_r <= `OFS_LOAD_SEL_RST;
            aux_output_select_r  <= `OFS_AUX_SEL_RST;
            pwm_select_r         <= `OFS_PWM_NONE;
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                `OFS_REG_LOAD_SEL: begin
                    load_output_select_r <= reg_wdata[3:0];
                end
                `OFS_REG_AUX_SEL: begin
                    aux_output_select_r <= reg_wdata[3:0];
                end
                `OFS_REG_PWM_SEL: begin
                    pwm_select_r <= reg_wdata[1:0];
                end
                default: begin
                    pwm_select_r <= pwm_select_r;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-terminal decode, one shared instance body per terminal

    wire load_drive;
    wire aux_drive;

    ofs_term_mux u_load_mux (
        .sel      (load_output_select_r),
        .fn_lbd   (fn_lbd),
        .fn_gen   (fn_gen),
        .fn_evt   (fn_evt),
        .fn_bat2  (fn_bat2),
        .fn_alarm (fn_alarm),
        .fn_div   (fn_div),
        .drive_on (load_drive)
    );

    ofs_term_mux u_aux_mux (
        .sel      (aux_output_select_r),
        .fn_lbd   (fn_lbd),
        .fn_gen   (fn_gen),
        .fn_evt   (fn_evt),
        .fn_bat2  (fn_bat2),
        .fn_alarm (fn_alarm),
        .fn_div   (fn_div),
        .drive_on (aux_drive)
    );

    ////////////////////////////////////////////////////////////////////
    // modulation gating and output registers

    wire load_is_div;
    wire load_pwm;
    wire bad_cfg;

    // only code 10 may be modulated; an illegal 11 is left unmodulated
    assign load_is_div = (load_output_select_r == `OFS_SEL_DIV_REG);
    assign load_pwm    = pwm_on_load(pwm_select_r) && load_is_div;
    // flagged so software can see the forbidden pairing
    assign bad_cfg     = pwm_on_load(pwm_select_r) &&
                         (load_output_select_r == `OFS_SEL_DIV_INV);

    wire solar_pwm;
    assign solar_pwm = (pwm_select_r == `OFS_PWM_SOLAR) ||
                       (pwm_select_r == `OFS_PWM_BOTH);

    // load pwm gates only the dump load; charge source path untouched by it
    always @(posedge clk_sys) begin
        if (rst) begin
            load_out            <= 1'b0;
            aux_out             <= 1'b0;
            solar_out           <= 1'b0;
            load_indicator      <= 1'b0;
            generator_indicator <= 1'b0;
        end else if (clk_en) begin
            load_out  <= load_drive & (~load_pwm | pwm_tick);
            aux_out   <= aux_drive;
            // series path independent of diversion selection
            solar_out <= series_on & (~solar_pwm | pwm_tick);
            load_indicator      <= fn_lbd;
            generator_indicator <= fn_gen;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read port: data in the cycle after the strobe

    always @* begin
        case (reg_addr)
            `OFS_REG_LOAD_SEL: rdata_nxt = {4'h0, load_output_select_r};
            `OFS_REG_AUX_SEL:  rdata_nxt = {4'h0, aux_output_select_r};
            `OFS_REG_PWM_SEL:  rdata_nxt = {6'h00, pwm_select_r};
            `OFS_REG_STATUS:   rdata_nxt = {3'h0, bad_cfg,
                                            generator_indicator,
                                            load_indicator,
                                            aux_out, load_out};
            default:           rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
        end
    end

endmodule

// ===== testbench/ofs_chk_assertions.sv
// port checks for ofs_output_select
// assumes: bound to the top module, one clock, rst synchronous
`timescale 1ns/100ps
module ofs_chk (
    input wire       clk_sys,
    input wire       rst,
    input wire       clk_en,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       fn_lbd,
    input wire       fn_gen,
    input wire       fn_evt,
    input wire       fn_bat2,
    input wire       fn_alarm,
    input wire       fn_div,
    input wire       load_out,
    input wire       aux_out,
    input wire       solar_out,
    input wire       load_indicator,
    input wire       generator_indicator
);
default clocking @(posedge clk_sys); endclocking
default disable iff (rst);
wire [5:0] fn_all = {fn_div, fn_alarm, fn_bat2, fn_evt, fn_gen, fn_lbd};
reg        run_r;
reg        run2_r;
// enabled, out-of-reset history; a frozen edge must not count as cause
always @(posedge clk_sys) begin
    run_r <= clk_en && !rst;
    run2_r <= run_r;
end
////////////////////////////////////////////////////////////////////////
property p_li; run_r |-> load_indicator == $past(fn_lbd); endproperty
a_li: assert property (p_li) else $error("load indicator lag");
property p_gi; run_r |-> generator_indicator == $past(fn_gen); endproperty
a_gi: assert property (p_gi) else $error("gen indicator lag");
property p_aux; run_r && run2_r && $changed(aux_out) |->
    $past(fn_all) != $past(fn_all, 2) || $past(reg_wr, 2); endproperty
a_aux: assert property (p_aux) else $error("aux moved alone");
property p_rd; run_r && !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
a_rd: assert property (p_rd) else $error("stray read data");
property p_fl; !$past(clk_en) && $past(!rst) |-> $stable(load_out);
endproperty
a_fl: assert property (p_fl) else $error("load moved frozen");
property p_fa; !$past(clk_en) && $past(!rst) |-> $stable(aux_out);
endproperty
a_fa: assert property (p_fa) else $error("aux moved frozen");
property p_fs; !$past(clk_en) && $past(!rst) |-> $stable(solar_out);
endproperty
a_fs: assert property (p_fs) else $error("solar moved frozen");
property p_rs; $past(rst && clk_en) |-> !load_out && !aux_out; endproperty
a_rs: assert property (p_rs) else $error("output on after reset");
endmodule

// ===== testbench/ofs_relay_load.sv
// relay on the general terminal, dump load on the load terminal
// assumes: terminals are registered levels on clk_sys
`timescale 1ns/100ps
module ofs_relay_load (
    input  wire       clk_sys,
    input  wire       load_out,
    input  wire       aux_out,
    output reg  [7:0] aux_sw
);
reg aux_q = 1'b0;
wire dump_on = load_out;
// count relay operations; a slow relay cannot follow modulation
initial aux_sw = 8'h00;
always @(posedge clk_sys) begin
    aux_q <= aux_out;
    if (aux_q != aux_out) aux_sw <= aux_sw + 8'h01;
end
endmodule

// ===== testbench/tb.sv
// bench for ofs_output_select with a relay load model
// assumes: ofs_consts.vh on the include path
`timescale 1ns/100ps
`include "ofs_consts.vh"
module tb;
reg        clk_sys = 1'b0;
reg        rst = 1'b1;
reg        clk_en = 1'b1;
reg        reg_wr = 1'b0;
reg        reg_rd = 1'b0;
reg        pwm_tick = 1'b0;
reg        series_on = 1'b0;
reg  [3:0] reg_addr = 4'h0;
reg  [7:0] reg_wdata = 8'h00;
reg  [5:0] fn = 6'h00;
reg  [7:0] rd_v;
reg  [7:0] sw0;
reg        e;
wire [7:0] reg_rdata;
wire [7:0] aux_sw;
wire       load_out, aux_out, solar_out, l_ind, g_ind;
integer    n_fail = 0, total_checks = 0, c, p;
always #5 clk_sys = ~clk_sys;
ofs_output_select i_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fn_lbd(fn[0]),
    .fn_gen(fn[1]), .fn_evt(fn[2]), .fn_bat2(fn[3]), .fn_alarm(fn[4]),
    .fn_div(fn[5]), .pwm_tick(pwm_tick), .series_on(series_on),
    .load_out(load_out), .aux_out(aux_out), .solar_out(solar_out),
    .load_indicator(l_ind), .generator_indicator(g_ind));
ofs_relay_load i_load (.clk_sys(clk_sys), .load_out(load_out),
    .aux_out(aux_out), .aux_sw(aux_sw));
////////////////////////////////////////////////////////////////////////
task wr(input [3:0] a, input [7:0] d);
    begin
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    end
endtask
task rd(input [3:0] a);
    begin
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    end
endtask
task chk(input [7:0] got, input [7:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: got %h, exp %h", $time, got, exp);
        end
    end
endtask
task settle;
    begin
        repeat (3) @(posedge clk_sys);
        #1;
    end
endtask
task complete_run;
    begin
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
endtask
////////////////////////////////////////////////////////////////////////
// watchdog, well past the roughly 520 cycles the tests need
initial begin
    #100000;
    n_fail = n_fail + 1;
    complete_run;
end
// main sequence
initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`OFS_REG_LOAD_SEL);
    chk(rd_v, 8'h01);
    rd(`OFS_REG_AUX_SEL);
    chk(rd_v, 8'h02);
    rd(4'h2);
    chk(rd_v, 8'h00);
    $display("defaults done");
    // all sixteen codes on both terminals, four function patterns
    for (c = 0; c < 16; c = c + 1) begin
        for (p = 0; p < 4; p = p + 1) begin
            wr(`OFS_REG_LOAD_SEL, c[7:0]);
            wr(`OFS_REG_AUX_SEL, c[7:0]);
            fn <= (p[0] ? 6'h15 : 6'h00) ^ (p[1] ? 6'h3F : 6'h00);
            settle;
            e = (c > 11) ? 1'b0 : fn[c[3:1]] ^ c[0] ^ c[3];
            chk({7'h00, load_out}, {7'h00, e});
            chk({7'h00, aux_out}, {7'h00, e});
        end
    end
    $display("code table done");
    // load modulated under code 10, general terminal stays still
    wr(`OFS_REG_PWM_SEL, 8'h02);
    wr(`OFS_REG_LOAD_SEL, 8'h0A);
    wr(`OFS_REG_AUX_SEL, 8'h0A);
    fn <= 6'h00;
    settle;
    sw0 = aux_sw;
    for (p = 0; p < 4; p = p + 1) begin
        pwm_tick <= p[0];
        settle;
        chk({7'h00, load_out}, {7'h00, p[0]});
        chk({7'h00, aux_out}, 8'h01);
    end
    chk(aux_sw, sw0);
    // code 11 with load modulation: flagged in status, load left on whatever the tick
    wr(`OFS_REG_LOAD_SEL, 8'h0B);
    fn <= 6'h23;
    settle;
    rd(`OFS_REG_STATUS);
    chk(rd_v, 8'h1D);
    // series switch modulated while diversion keeps the load on
    wr(`OFS_REG_PWM_SEL, 8'h01);
    series_on <= 1'b1;
    pwm_tick <= 1'b1;
    settle;
    chk({6'h00, solar_out, load_out}, 8'h03);
    pwm_tick <= 1'b0;
    settle;
    chk({6'h00, solar_out, load_out}, 8'h01);
    // clock enable low freezes indicators and terminals
    clk_en <= 1'b0;
    fn <= 6'h00;
    settle;
    chk({6'h00, g_ind, l_ind}, 8'h03);
    clk_en <= 1'b1;
    settle;
    chk({6'h00, g_ind, l_ind}, 8'h00);
    // both paths modulated, off phase: dump load and series both off
    wr(`OFS_REG_PWM_SEL, 8'h03);
    wr(`OFS_REG_LOAD_SEL, 8'h0A);
    pwm_tick <= 1'b0;
    settle;
    chk({6'h00, solar_out, load_out}, 8'h00);
    rd(`OFS_REG_PWM_SEL);
    chk(rd_v, 8'h03);
    // mid-run reset: terminals off, load selection back to its default
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk({6'h00, aux_out, load_out}, 8'h00);
    rd(`OFS_REG_LOAD_SEL);
    chk(rd_v, 8'h01);
    $display("modulation done");
    complete_run;
end
endmodule
bind ofs_output_select ofs_chk i_chk (.clk_sys(clk_sys), .rst(rst),
    .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fn_lbd(fn_lbd), .fn_gen(fn_gen),
    .fn_evt(fn_evt), .fn_bat2(fn_bat2), .fn_alarm(fn_alarm),
    .fn_div(fn_div), .load_out(load_out), .aux_out(aux_out),
    .solar_out(solar_out), .load_indicator(load_indicator),
    .generator_indicator(generator_indicator));
